// ==== logic/bdsr_pkg.sv ====
// constants and types shared by the bias dac source select register bank
package bdsr_pkg;
    localparam int unsigned ADDR_W = 9;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ROW_W  = 6;
    localparam int unsigned LUT_DEPTH = 128;
    localparam int unsigned LUT_IDX_W = 7;

    localparam logic [8:0] ADDR_TABLE_ONE_ROW = 9'h081;
    localparam logic [8:0] ADDR_TABLE_TWO_ROW = 9'h082;
    localparam logic [8:0] ADDR_DAC1_CODE = 9'h083;
    localparam logic [8:0] ADDR_DAC2_CODE = 9'h084;
    localparam logic [8:0] ADDR_CFG      = 9'h085;
    localparam logic [8:0] ADDR_WEN      = 9'h086;
    localparam logic [8:0] ADDR_STATUS   = 9'h087;
    localparam logic [8:0] ADDR_RSVD_LO  = 9'h088;
    localparam logic [8:0] ADDR_RSVD_HI  = 9'h08F;
    localparam logic [8:0] TABLE_ONE_BASE     = 9'h090;
    localparam logic [8:0] TABLE_TWO_BASE     = 9'h0D0;
    localparam logic [8:0] LUT_LAST      = 9'h10F;

    localparam int unsigned CFG_DAC2_SRC  = 7;
    localparam int unsigned CFG_TABLE_TWO_SRC  = 6;
    localparam int unsigned CFG_DAC1_SRC  = 5;
    localparam int unsigned CFG_TABLE_ONE_SRC  = 4;
    localparam int unsigned CFG_GEN2_FS_LSB = 2;
    localparam int unsigned CFG_GEN1_FS_LSB = 0;
    localparam int unsigned WEN_BIT       = 7;
    localparam int unsigned STATUS_ADC_LSB = 2;

    localparam logic [7:0] WEN_SET_CODE   = 8'h80;
    localparam logic [7:0] WEN_CLEAR_CODE = 8'h00;
    localparam logic [7:0] CFG_RESET      = 8'h00;
    localparam logic [7:0] CODE_RESET     = 8'h00;
    localparam logic [5:0] ROW_RESET      = 6'h00;
    localparam logic [7:0] READ_ZERO      = 8'h00;

    typedef enum logic [1:0] {
        FS_EXTERNAL,
        FS_LOW,
        FS_MIDDLE,
        FS_HIGH
    } bdsr_fs_t;
endpackage

// ==== logic/bdsr_lut_mem.sv ====
// two look-up tables in one array, one write port and two registered read ports
`timescale 1ns/1ps
`default_nettype none
module bdsr_lut_mem #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 128
) (
    input  wire logic                     clk_in,
    input  wire logic                     rst_n_in,
    input  wire logic                     we_in,
    input  wire logic [$clog2(DEPTH)-1:0] waddr_in,
    input  wire logic [WIDTH-1:0]         wdata_in,
    input  wire logic [$clog2(DEPTH)-1:0] raddr_a_in,
    input  wire logic [$clog2(DEPTH)-1:0] raddr_b_in,
    output var  logic [WIDTH-1:0]         rdata_a_out,
    output var  logic [WIDTH-1:0]         rdata_b_out
);
    logic [WIDTH-1:0] mem_r [DEPTH];

    if (DEPTH < 2 || WIDTH < 1)
    begin : g_bad
        $error("bdsr_lut_mem: depth or width too small");
    end

    // table contents carry no reset; only the read registers do
    always_ff @(posedge clk_in)
    begin
        if (we_in)
        begin
            mem_r[waddr_in] <= wdata_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rdata_a_out <= '0;
            rdata_b_out <= '0;
        end
        else
        begin
            rdata_a_out <= mem_r[raddr_a_in];
            rdata_b_out <= mem_r[raddr_b_in];
        end
    end
endmodule
`default_nettype wire

// ==== logic/bdsr_regs.sv ====
// control register bank steering the two bias dacs and their look-up tables
//
// How it works
// R1: addresses 88h to 8Fh do nothing
// R2: generator two polarity resets to source
// R3: table one row override at 81h
// R4: table one row from override or converter
// R5: table one byte address is 90h plus row
// R6: table two row override at 82h
// R7: table two row from override or converter
// R8: table two byte address is D0h plus row
// R9: dac one direct code at 83h
// R10: dac one takes direct code or table
// R11: dac two direct code at 84h
// R12: dac two takes direct code or table
// R13: config register at 85h, resets zero
// R14: generator one full-scale field decoding
// R15: generator two full-scale field decoding
// R16: write enable register at 86h
// R17: clear latch aborts writes with no ack
// R18: latch resets clear, 80h sets, 00h clears
// R19: latch write leaves other bits alone
// R20: converter status at 87h is read-only
// R21: write enable register always writable
`timescale 1ns/1ps
`default_nettype none
module bdsr_regs #(
    parameter int unsigned ROW_WIDTH = bdsr_pkg::ROW_W
) (
    input  wire logic                        clk_sys_in,
    input  wire logic                        rstn_in,
    input  wire logic                        wr_in,
    input  wire logic                        rd_in,
    input  wire logic [bdsr_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [bdsr_pkg::DATA_W-1:0] wdata_in,
    input  wire logic                        volatility_select_in,
    input  wire logic                        gen1_polarity_select_in,
    input  wire logic                        gen2_polarity_select_in,
    input  wire logic [5:0]                  converter_result_bits_in,
    output var  logic                        ack_out,
    output var  logic                        nack_out,
    output var  logic                        rvalid_out,
    output var  logic [bdsr_pkg::DATA_W-1:0] rdata_out,
    output var  logic                        nv_commit_out,
    output var  logic [bdsr_pkg::ADDR_W-1:0] nv_addr_out,
    output var  logic [bdsr_pkg::DATA_W-1:0] nv_data_out,
    output var  logic [bdsr_pkg::ADDR_W-1:0] table_one_byte_addr_out,
    output var  logic [bdsr_pkg::ADDR_W-1:0] table_two_byte_addr_out,
    output var  logic [7:0]                  dac_one_code_out,
    output var  logic [7:0]                  dac_two_code_out,
    output var  bdsr_pkg::bdsr_fs_t          gen1_full_scale_sel_out,
    output var  bdsr_pkg::bdsr_fs_t          gen2_full_scale_sel_out,
    output var  logic                        gen1_sink_out,
    output var  logic                        gen2_sink_out,
    output var  logic                        write_enable_latch_out
);
    import bdsr_pkg::*;

    if (ROW_WIDTH != ROW_W)
    begin : g_bad_row
        $error("bdsr_regs: table rows are fixed at six bits");
    end

    logic rst_meta_r;
    logic rst_n;

    // release is synchronised so every register leaves reset on the same edge
    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    logic [5:0] table_one_ovr_r, table_one_ovr_nxt;
    logic [5:0] table_two_ovr_r, table_two_ovr_nxt;
    logic [7:0] dac1_dir_r, dac1_dir_nxt;
    logic [7:0] dac2_dir_r, dac2_dir_nxt;
    logic [7:0] cfg_r, cfg_nxt;
    logic       wel_r, wel_nxt;
    logic       ack_nxt, nack_nxt, rvalid_nxt, nv_nxt;
    logic [7:0] rdata_nxt;
    logic [8:0] tbl1_addr_nxt, tbl2_addr_nxt;
    logic [7:0] dac1_nxt, dac2_nxt;
    logic       wr_wen, wr_ok, lut_we;
    logic [5:0] row1, row2;
    logic [LUT_IDX_W-1:0] lut_widx, lut_ridx1, lut_ridx2;
    logic [7:0] lut_rd1, lut_rd2;

    always_comb
    begin
        table_one_ovr_nxt = table_one_ovr_r;
        table_two_ovr_nxt = table_two_ovr_r;
        dac1_dir_nxt = dac1_dir_r;
        dac2_dir_nxt = dac2_dir_r;
        cfg_nxt      = cfg_r;
        wel_nxt      = wel_r;
        wr_wen       = wr_in && (addr_in == ADDR_WEN);
        // R21: latch register open
        // R17: latch gates writes
        wr_ok        = wr_in && (wel_r || wr_wen);
        ack_nxt      = wr_ok;
        nack_nxt     = wr_in && !wr_ok;
        nv_nxt       = 1'b0;
        lut_we       = 1'b0;
        lut_widx     = LUT_IDX_W'(addr_in - TABLE_ONE_BASE);
        if (wr_ok)
        begin
            // R3: table one override
            if (addr_in == ADDR_TABLE_ONE_ROW)
            begin
                table_one_ovr_nxt = wdata_in[5:0];
                nv_nxt       = volatility_select_in;
            end
            // R6: table two override
            else if (addr_in == ADDR_TABLE_TWO_ROW)
            begin
                table_two_ovr_nxt = wdata_in[5:0];
                nv_nxt       = volatility_select_in;
            end
            // R9: dac one code
            else if (addr_in == ADDR_DAC1_CODE)
            begin
                dac1_dir_nxt = wdata_in;
                nv_nxt       = volatility_select_in;
            end
            // R11: dac two code
            else if (addr_in == ADDR_DAC2_CODE)
            begin
                dac2_dir_nxt = wdata_in;
                nv_nxt       = volatility_select_in;
            end
            // R13: config always nonvolatile
            else if (addr_in == ADDR_CFG)
            begin
                cfg_nxt = wdata_in;
                nv_nxt  = 1'b1;
            end
            // R18: set or clear latch
            // R19: other bits untouched
            else if (addr_in == ADDR_WEN)
            begin
                if (wdata_in == WEN_SET_CODE)
                begin
                    wel_nxt = 1'b1;
                end
                else if (wdata_in == WEN_CLEAR_CODE)
                begin
                    wel_nxt = 1'b0;
                end
            end
            else if (addr_in >= TABLE_ONE_BASE && addr_in <= LUT_LAST)
            begin
                lut_we = 1'b1;
                nv_nxt = 1'b1;
            end
            // R1: reserved range ignored
            // R20: status write ignored
        end
        rvalid_nxt = rd_in;
        if (!rd_in)
        begin
            rdata_nxt = READ_ZERO;
        end
        else if (addr_in == ADDR_TABLE_ONE_ROW)
        begin
            rdata_nxt = {2'b00, table_one_ovr_r};
        end
        else if (addr_in == ADDR_TABLE_TWO_ROW)
        begin
            rdata_nxt = {2'b00, table_two_ovr_r};
        end
        else if (addr_in == ADDR_DAC1_CODE)
        begin
            rdata_nxt = dac1_dir_r;
        end
        else if (addr_in == ADDR_DAC2_CODE)
        begin
            rdata_nxt = dac2_dir_r;
        end
        else if (addr_in == ADDR_CFG)
        begin
            rdata_nxt = cfg_r;
        end
        // R16: latch register readback
        else if (addr_in == ADDR_WEN)
        begin
            rdata_nxt = {wel_r, 7'h00};
        end
        // R20: converter result readback
        else if (addr_in == ADDR_STATUS)
        begin
            rdata_nxt = {converter_result_bits_in, 2'b00};
        end
        else
        begin
            rdata_nxt = READ_ZERO;
        end
    end

    // R4: table one row source
    // R7: table two row source
    always_comb
    begin
        row1 = cfg_r[CFG_TABLE_ONE_SRC] ? table_one_ovr_r : converter_result_bits_in;
        row2 = cfg_r[CFG_TABLE_TWO_SRC] ? table_two_ovr_r : converter_result_bits_in;
        // R5: base plus row
        tbl1_addr_nxt = TABLE_ONE_BASE + {3'b000, row1};
        // R8: base plus row
        tbl2_addr_nxt = TABLE_TWO_BASE + {3'b000, row2};
        lut_ridx1 = LUT_IDX_W'(tbl1_addr_nxt - TABLE_ONE_BASE);
        lut_ridx2 = LUT_IDX_W'(tbl2_addr_nxt - TABLE_ONE_BASE);
        // R10: dac one source
        dac1_nxt = cfg_r[CFG_DAC1_SRC] ? dac1_dir_r : lut_rd1;
        // R12: dac two source
        dac2_nxt = cfg_r[CFG_DAC2_SRC] ? dac2_dir_r : lut_rd2;
    end

    // table read is registered, so a direct code reaches its dac one cycle before a table row does
    bdsr_lut_mem #(
        .WIDTH (8),
        .DEPTH (LUT_DEPTH)
    ) u_lut (
        .clk_in      (clk_sys_in),
        .rst_n_in    (rst_n),
        .we_in       (lut_we),
        .waddr_in    (lut_widx),
        .wdata_in    (wdata_in),
        .raddr_a_in  (lut_ridx1),
        .raddr_b_in  (lut_ridx2),
        .rdata_a_out (lut_rd1),
        .rdata_b_out (lut_rd2)
    );

    always_ff @(posedge clk_sys_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            table_one_ovr_r <= ROW_RESET;
            table_two_ovr_r <= ROW_RESET;
            dac1_dir_r <= CODE_RESET;
            dac2_dir_r <= CODE_RESET;
            // R13: config defaults zero
            cfg_r      <= CFG_RESET;
            // R18: latch powers up clear
            wel_r      <= 1'b0;
            ack_out    <= 1'b0;
            nack_out   <= 1'b0;
            rvalid_out <= 1'b0;
            rdata_out  <= READ_ZERO;
            nv_commit_out <= 1'b0;
            nv_addr_out   <= '0;
            nv_data_out   <= '0;
            table_one_byte_addr_out <= TABLE_ONE_BASE;
            table_two_byte_addr_out <= TABLE_TWO_BASE;
            dac_one_code_out <= CODE_RESET;
            dac_two_code_out <= CODE_RESET;
            // R2: source by default
            gen1_sink_out <= 1'b0;
            gen2_sink_out <= 1'b0;
        end
        else
        begin
            table_one_ovr_r <= table_one_ovr_nxt;
            table_two_ovr_r <= table_two_ovr_nxt;
            dac1_dir_r <= dac1_dir_nxt;
            dac2_dir_r <= dac2_dir_nxt;
            cfg_r      <= cfg_nxt;
            wel_r      <= wel_nxt;
            ack_out    <= ack_nxt;
            nack_out   <= nack_nxt;
            rvalid_out <= rvalid_nxt;
            rdata_out  <= rdata_nxt;
            nv_commit_out <= nv_nxt;
            nv_addr_out   <= addr_in;
            nv_data_out   <= wdata_in;
            table_one_byte_addr_out <= tbl1_addr_nxt;
            table_two_byte_addr_out <= tbl2_addr_nxt;
            dac_one_code_out <= dac1_nxt;
            dac_two_code_out <= dac2_nxt;
            // R2: polarity follows select
            gen1_sink_out <= gen1_polarity_select_in;
            gen2_sink_out <= gen2_polarity_select_in;
        end
    end

    // R14: generator one decoding
    // R15: generator two decoding
    assign gen1_full_scale_sel_out = bdsr_fs_t'(cfg_r[CFG_GEN1_FS_LSB +: 2]);
    assign gen2_full_scale_sel_out = bdsr_fs_t'(cfg_r[CFG_GEN2_FS_LSB +: 2]);
    assign write_enable_latch_out  = wel_r;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n);

    a_rsvd_no_effect: assert property (wr_in && addr_in >= ADDR_RSVD_LO && addr_in <= ADDR_RSVD_HI |=> // R1
        $stable(cfg_r) && $stable(wel_r) && $stable(dac1_dir_r) && $stable(table_one_ovr_r)) else $error("reserved write changed state");
    a_gen2_polarity: assert property (##1 gen2_sink_out == $past(gen2_polarity_select_in)) // R2
        else $error("gen2 polarity mismatch");
    a_table_one_ovr_store: assert property (wr_in && wel_r && addr_in == ADDR_TABLE_ONE_ROW |=> // R3
        table_one_ovr_r == $past(wdata_in[5:0])) else $error("table one override not stored");
    a_table_one_ovr_read: assert property (rd_in && addr_in == ADDR_TABLE_ONE_ROW |=> // R3
        rdata_out == {2'b00, $past(table_one_ovr_r)}) else $error("table one override readback wrong");
    a_tbl1_addr: assert property (##1 table_one_byte_addr_out == TABLE_ONE_BASE + // R4
        {3'b000, $past(cfg_r[CFG_TABLE_ONE_SRC]) ? $past(table_one_ovr_r) : $past(converter_result_bits_in)}) else $error("table one address wrong");
    a_tbl2_addr: assert property (##1 table_two_byte_addr_out == TABLE_TWO_BASE + // R8
        {3'b000, $past(cfg_r[CFG_TABLE_TWO_SRC]) ? $past(table_two_ovr_r) : $past(converter_result_bits_in)}) else $error("table two address wrong");
    a_dac1_direct: assert property (cfg_r[CFG_DAC1_SRC] |=> dac_one_code_out == $past(dac1_dir_r)) // R10
        else $error("dac one ignores direct code");
    a_dac2_direct: assert property (cfg_r[CFG_DAC2_SRC] |=> dac_two_code_out == $past(dac2_dir_r)) // R12
        else $error("dac two ignores direct code");
    a_cfg_commit: assert property (wr_in && wel_r && addr_in == ADDR_CFG |=> nv_commit_out && cfg_r == $past(wdata_in)) // R13
        else $error("config write lost");
    a_wel_gate: assert property (wr_in && !wel_r && addr_in != ADDR_WEN |=> nack_out && !ack_out && $stable(cfg_r)) // R17
        else $error("write passed with latch clear");
    a_wel_set_clear: assert property (wr_in && addr_in == ADDR_WEN && (wdata_in == WEN_SET_CODE || wdata_in == WEN_CLEAR_CODE) // R18
        |=> wel_r == $past(wdata_in[WEN_BIT]) && ack_out) else $error("latch did not follow write");
    a_wel_hold: assert property (!(wr_in && addr_in == ADDR_WEN) |=> $stable(wel_r)) // R18
        else $error("latch changed without write");
    a_status_read: assert property (rd_in && addr_in == ADDR_STATUS |=> rvalid_out && // R20
        rdata_out == {$past(converter_result_bits_in), 2'b00}) else $error("status readback wrong");

    c_wel_then_write: cover property (wr_in && addr_in == ADDR_WEN && wdata_in == WEN_SET_CODE ##1 wr_in ##1 ack_out);
    c_nack: cover property (nack_out);
    c_dac1_direct: cover property (cfg_r[CFG_DAC1_SRC] ##1 dac_one_code_out != 8'h00);
    c_lut_override: cover property (cfg_r[CFG_TABLE_TWO_SRC] && table_two_ovr_r == 6'h3F);
endmodule
`default_nettype wire

// ==== tb/bdsr_host_model.sv ====
// behavioural host issuing single-byte register requests
`timescale 1ns/1ps
`default_nettype none
module bdsr_host_model (
    input  wire logic       clk_in,
    input  wire logic       ack_in,
    input  wire logic       nack_in,
    input  wire logic       rvalid_in,
    input  wire logic [7:0] rdata_in,
    output var  logic       wr_out,
    output var  logic       rd_out,
    output var  logic [8:0] addr_out,
    output var  logic [7:0] wdata_out
);
    initial
    begin
        wr_out    = 1'b0;
        rd_out    = 1'b0;
        addr_out  = 9'h000;
        wdata_out = 8'h00;
    end

    // released lines carry the inverse so a stale value never passes
    task automatic wr_byte(input logic [8:0] a, input logic [7:0] d, output logic ok, output logic nk);
        @(posedge clk_in);
        wr_out    <= 1'b1;
        addr_out  <= a;
        wdata_out <= d;
        @(posedge clk_in);
        wr_out    <= 1'b0;
        addr_out  <= ~a;
        wdata_out <= ~d;
        @(negedge clk_in);
        ok = ack_in;
        nk = nack_in;
    endtask

    task automatic rd_byte(input logic [8:0] a, output logic v, output logic [7:0] d);
        @(posedge clk_in);
        rd_out   <= 1'b1;
        addr_out <= a;
        @(posedge clk_in);
        rd_out   <= 1'b0;
        addr_out <= ~a;
        @(negedge clk_in);
        v = rvalid_in;
        d = rdata_in;
    endtask
endmodule
`default_nettype wire

// ==== tb/test_bdsr_regs.sv ====
// self-checking bench for the bias dac source select register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module test_bdsr_regs;
    import bdsr_pkg::*;
    logic       clk_sys_in = 1'b0;
    logic       rstn_in    = 1'b0;
    logic       vol_sel    = 1'b0;
    logic       pol1       = 1'b0;
    logic       pol2       = 1'b0;
    logic [5:0] conv       = 6'h00;
    wire  logic wr, rd, ack, nack, rvalid, commit, sink1, sink2, write_enable_latch;
    wire  logic [8:0] addr, nva, tb1, tb2;
    wire  logic [7:0] wdata, rdata, nvd, d1, d2;
    bdsr_fs_t   fs1, fs2;
    logic [7:0] m_row1, m_row2, m_code1, m_code2, m_cfg;
    logic       m_wel;
    logic [7:0] lut [0:127];
    int         errors = 0;
    int         total_checks = 0;
    int         cycles = 0;

    bdsr_regs #(.ROW_WIDTH(6)) uut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .wr_in(wr), .rd_in(rd),
        .addr_in(addr), .wdata_in(wdata), .volatility_select_in(vol_sel), .gen1_polarity_select_in(pol1),
        .gen2_polarity_select_in(pol2), .converter_result_bits_in(conv), .ack_out(ack), .nack_out(nack),
        .rvalid_out(rvalid), .rdata_out(rdata), .nv_commit_out(commit), .nv_addr_out(nva), .nv_data_out(nvd),
        .table_one_byte_addr_out(tb1), .table_two_byte_addr_out(tb2), .dac_one_code_out(d1),
        .dac_two_code_out(d2), .gen1_full_scale_sel_out(fs1), .gen2_full_scale_sel_out(fs2),
        .gen1_sink_out(sink1), .gen2_sink_out(sink2), .write_enable_latch_out(write_enable_latch));

    bdsr_host_model host (.clk_in(clk_sys_in), .ack_in(ack), .nack_in(nack), .rvalid_in(rvalid),
        .rdata_in(rdata), .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wdata));

    always #2 clk_sys_in = ~clk_sys_in;

    // run needs about 2100 cycles; ceiling leaves wide margin
    always @(posedge clk_sys_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    function automatic logic [8:0] exp_tbl(input logic sel, input logic [7:0] row, input logic [8:0] base);
        return base + {3'b000, (sel ? row[5:0] : conv)};
    endfunction

    function automatic logic [7:0] exp_rd(input logic [8:0] a);
        case (a)
            ADDR_TABLE_ONE_ROW:  return m_row1;
            ADDR_TABLE_TWO_ROW:  return m_row2;
            ADDR_DAC1_CODE: return m_code1;
            ADDR_DAC2_CODE: return m_code2;
            ADDR_CFG:       return m_cfg;
            ADDR_WEN:       return {m_wel, 7'h00};
            ADDR_STATUS:    return {conv, 2'b00};
            default:        return READ_ZERO;
        endcase
    endfunction

    task automatic wr_chk(input logic [8:0] a, input logic [7:0] d);
        logic ok;
        logic nk;
        logic exp_ok;
        logic exp_cm;
        exp_ok = m_wel || (a == ADDR_WEN);
        host.wr_byte(a, d, ok, nk);
        // volatility select may be updated in the step of the call, so judge the commit after the request
        exp_cm = exp_ok && ((a >= TABLE_ONE_BASE && a <= LUT_LAST) || a == ADDR_CFG
                 || (vol_sel && a >= ADDR_TABLE_ONE_ROW && a <= ADDR_DAC2_CODE));
        `CHK(ok, exp_ok)
        `CHK(nk, ~exp_ok)
        `CHK(commit, exp_cm)
        if (exp_cm)
            `CHK({nva, nvd}, {a, d})
        if (exp_ok)
        begin
            case (a)
                ADDR_TABLE_ONE_ROW:  m_row1 = {2'b00, d[5:0]};
                ADDR_TABLE_TWO_ROW:  m_row2 = {2'b00, d[5:0]};
                ADDR_DAC1_CODE: m_code1 = d;
                ADDR_DAC2_CODE: m_code2 = d;
                ADDR_CFG:       m_cfg = d;
                ADDR_WEN:       m_wel = (d == WEN_SET_CODE) ? 1'b1 : (d == WEN_CLEAR_CODE) ? 1'b0 : m_wel;
                default:        if (a >= TABLE_ONE_BASE && a <= LUT_LAST) lut[7'(a - TABLE_ONE_BASE)] = d;
            endcase
        end
    endtask

    task automatic rd_chk(input logic [8:0] a);
        logic       v;
        logic [7:0] d;
        host.rd_byte(a, v, d);
        `CHK(v, 1'b1)
        `CHK(d, exp_rd(a))
    endtask

    task automatic check_all();
        logic [8:0] e1;
        logic [8:0] e2;
        repeat (4) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        e1 = exp_tbl(m_cfg[4], m_row1, TABLE_ONE_BASE);
        e2 = exp_tbl(m_cfg[6], m_row2, TABLE_TWO_BASE);
        `CHK(tb1, e1)
        `CHK(tb2, e2)
        `CHK(d1, m_cfg[5] ? m_code1 : lut[7'(e1 - TABLE_ONE_BASE)])
        `CHK(d2, m_cfg[7] ? m_code2 : lut[7'(e2 - TABLE_ONE_BASE)])
        `CHK(fs1, bdsr_fs_t'(m_cfg[1:0]))
        `CHK(fs2, bdsr_fs_t'(m_cfg[3:2]))
        `CHK({sink1, sink2}, {pol1, pol2})
        `CHK(write_enable_latch, m_wel)
        for (int a = 9'h081; a <= 9'h08F; a++)
            rd_chk(9'(a));
    endtask

    initial
    begin
        void'($urandom(32'h7B43));
        {m_row1, m_row2, m_code1, m_code2, m_cfg} = '0;
        m_wel = 1'b0;
        repeat (8) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        `CHK({tb1, tb2}, {9'h090, 9'h0D0})
        `CHK({fs1, fs2, sink2, write_enable_latch}, {FS_EXTERNAL, FS_EXTERNAL, 1'b0, 1'b0})
        for (int a = 9'h081; a <= 9'h087; a++)
            rd_chk(9'(a));
        wr_chk(ADDR_DAC1_CODE, 8'h5A);
        wr_chk(ADDR_WEN, 8'h55);
        wr_chk(ADDR_WEN, WEN_SET_CODE);
        wr_chk(ADDR_WEN, 8'h81);
        rd_chk(ADDR_WEN);
        for (int i = 0; i < 128; i++)
            wr_chk(TABLE_ONE_BASE + 9'(i), 8'($urandom));
        for (int i = 0; i < 4; i++)
        begin
            wr_chk(ADDR_CFG, {4'h0, 2'(i), 2'(3 - i)});
            check_all();
        end
        for (int n = 0; n < 40; n++)
        begin
            @(posedge clk_sys_in);
            conv    <= 6'($urandom);
            pol1    <= 1'($urandom);
            pol2    <= 1'($urandom);
            vol_sel <= 1'($urandom);
            wr_chk(ADDR_TABLE_ONE_ROW + 9'($urandom_range(0, 4)), 8'($urandom));
            wr_chk(ADDR_CFG, 8'($urandom));
            check_all();
        end
        for (int a = 9'h087; a <= 9'h08F; a++)
            wr_chk(9'(a), 8'hFF);
        check_all();
        wr_chk(ADDR_WEN, WEN_CLEAR_CODE);
        wr_chk(ADDR_CFG, 8'hFF);
        check_all();
        wrap_up();
    end
endmodule
`default_nettype wire
